// ===== core/orsf_pkg.sv
// Package for the output regulation event flag register
package orsf_pkg;
  localparam int unsigned REG_W = 8;
  localparam logic [7:0] FLAGS_ADDR = 8'h01;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAGS_IMPL_MASK = 8'h3F;
  localparam int unsigned BIT_A_GOOD = 0;
  localparam int unsigned BIT_B_GOOD = 1;
  localparam int unsigned BIT_C_GOOD = 2;
  localparam int unsigned BIT_A_LOW = 3;
  localparam int unsigned BIT_B_LOW = 4;
  localparam int unsigned BIT_C_LOW = 5;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam int unsigned N_OUT = 3;
  localparam int unsigned IDX_A = 0;
  localparam int unsigned IDX_B = 1;
  localparam int unsigned IDX_C = 2;
  localparam logic [7:0] CLR_NONE = 8'h00;
  localparam logic [7:0] RD_IDLE = 8'h00;
  localparam logic [1:0] RSVD_PAD = 2'h0;

  // Register access from the serial register front end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } orsf_wr_t;

  // Live regulation levels, one bit per output: [0]=A, [1]=B, [2]=C
  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } orsf_live_t;
endpackage

// ===== core/orsf_flags.sv
// Sticky regulation transition flags with write-one-to-clear access
`timescale 1ns/1ps
`default_nettype none
module orsf_flags #(
  parameter int unsigned REG_W = orsf_pkg::REG_W,
  parameter int unsigned N_OUT = orsf_pkg::N_OUT
) (
  input wire logic clk,
  input wire logic rst,
  input wire orsf_pkg::orsf_live_t live_good,
  input wire orsf_pkg::orsf_wr_t bus_wr,
  input wire logic [REG_W-1:0] rd_addr,
  output logic [REG_W-1:0] rd_data,
  output logic [REG_W-1:0] flags
);
  // True when an address on either bus path selects this register
  function automatic logic addr_hit(input logic [REG_W-1:0] addr);
    return addr == orsf_pkg::FLAGS_ADDR;
  endfunction

  // Follow stage three only once stages two and three agree, so a
  // one-cycle glitch on a comparator never reaches the flags
  function automatic logic [N_OUT-1:0] settle(
    input logic [N_OUT-1:0] mid,
    input logic [N_OUT-1:0] last,
    input logic [N_OUT-1:0] held
  );
    logic [N_OUT-1:0] same;
    same = ~(mid ^ last);
    return (same & last) | (~same & held);
  endfunction

  // An event in the clearing cycle wins, so no transition is ever lost
  function automatic logic sticky_next(
    input logic cur,
    input logic ev,
    input logic wipe
  );
    return ev | (cur & ~wipe);
  endfunction

  // Comparator levels, high while an output is in regulation
  logic live_a;
  logic live_b;
  logic live_c;
  logic [N_OUT-1:0] live_raw;
  // Comparators run free of clk: three stages per output
  logic [N_OUT-1:0] s1_q;
  logic [N_OUT-1:0] s2_q;
  logic [N_OUT-1:0] s3_q;
  logic [N_OUT-1:0] level_q;
  logic [N_OUT-1:0] level_d;
  logic [N_OUT-1:0] rise;
  logic [N_OUT-1:0] fall;
  logic a_up;
  logic b_up;
  logic c_up;
  logic a_down;
  logic b_down;
  logic c_down;
  logic wr_hit;
  logic rd_hit;
  logic [REG_W-1:0] clr_vec;
  logic output_c_fell_out_flag_q;
  logic output_c_fell_out_flag_d;
  logic output_b_fell_out_flag_q;
  logic output_b_fell_out_flag_d;
  logic output_a_fell_out_flag_q;
  logic output_a_fell_out_flag_d;
  logic output_c_regained_flag_q;
  logic output_c_regained_flag_d;
  logic output_b_regained_flag_q;
  logic output_b_regained_flag_d;
  logic output_a_regained_flag_q;
  logic output_a_regained_flag_d;
  logic [REG_W-1:0] flag_word;
  logic [REG_W-1:0] rd_data_q;
  logic [REG_W-1:0] rd_data_d;

  assign live_a = live_good.a;
  assign live_b = live_good.b;
  assign live_c = live_good.c;
  assign live_raw = {live_c, live_b, live_a};

  assign level_d = settle(s2_q, s3_q, level_q);
  // Edges of the settled level only; a target change that never drops
  // the comparator produces no edge and so no good flag
  assign rise = level_d & ~level_q;
  assign fall = ~level_d & level_q;
  assign a_up = rise[orsf_pkg::IDX_A];
  assign b_up = rise[orsf_pkg::IDX_B];
  assign c_up = rise[orsf_pkg::IDX_C];
  assign a_down = fall[orsf_pkg::IDX_A];
  assign b_down = fall[orsf_pkg::IDX_B];
  assign c_down = fall[orsf_pkg::IDX_C];

  assign wr_hit = bus_wr.wr && addr_hit(bus_wr.addr);
  // Reserved bits ignored whatever the host writes
  assign clr_vec = wr_hit ?
    (bus_wr.wdata & orsf_pkg::FLAGS_IMPL_MASK) : orsf_pkg::CLR_NONE;

  assign output_c_fell_out_flag_d = sticky_next(output_c_fell_out_flag_q, c_down,
    clr_vec[orsf_pkg::BIT_C_LOW]);
  assign output_b_fell_out_flag_d = sticky_next(output_b_fell_out_flag_q, b_down,
    clr_vec[orsf_pkg::BIT_B_LOW]);
  assign output_a_fell_out_flag_d = sticky_next(output_a_fell_out_flag_q, a_down,
    clr_vec[orsf_pkg::BIT_A_LOW]);
  assign output_c_regained_flag_d = sticky_next(output_c_regained_flag_q, c_up,
    clr_vec[orsf_pkg::BIT_C_GOOD]);
  assign output_b_regained_flag_d = sticky_next(output_b_regained_flag_q, b_up,
    clr_vec[orsf_pkg::BIT_B_GOOD]);
  assign output_a_regained_flag_d = sticky_next(output_a_regained_flag_q, a_up,
    clr_vec[orsf_pkg::BIT_A_GOOD]);

  assign flag_word = {
    orsf_pkg::RSVD_PAD,
    output_c_fell_out_flag_q,
    output_b_fell_out_flag_q,
    output_a_fell_out_flag_q,
    output_c_regained_flag_q,
    output_b_regained_flag_q,
    output_a_regained_flag_q
  };

  assign rd_hit = addr_hit(rd_addr);
  // A read shows the register as it stood at the sampling edge
  assign rd_data_d = rd_hit ? flag_word : orsf_pkg::RD_IDLE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= orsf_pkg::SYNC_RESET;
    end else begin
      s1_q <= live_raw;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s2_q <= orsf_pkg::SYNC_RESET;
    end else begin
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s3_q <= orsf_pkg::SYNC_RESET;
    end else begin
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= orsf_pkg::SYNC_RESET;
    end else begin
      level_q <= level_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_c_fell_out_flag_q <= orsf_pkg::FLAGS_RESET[orsf_pkg::BIT_C_LOW];
    end else begin
      output_c_fell_out_flag_q <= output_c_fell_out_flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_b_fell_out_flag_q <= orsf_pkg::FLAGS_RESET[orsf_pkg::BIT_B_LOW];
    end else begin
      output_b_fell_out_flag_q <= output_b_fell_out_flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_a_fell_out_flag_q <= orsf_pkg::FLAGS_RESET[orsf_pkg::BIT_A_LOW];
    end else begin
      output_a_fell_out_flag_q <= output_a_fell_out_flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_c_regained_flag_q <= orsf_pkg::FLAGS_RESET[orsf_pkg::BIT_C_GOOD];
    end else begin
      output_c_regained_flag_q <= output_c_regained_flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_b_regained_flag_q <= orsf_pkg::FLAGS_RESET[orsf_pkg::BIT_B_GOOD];
    end else begin
      output_b_regained_flag_q <= output_b_regained_flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_a_regained_flag_q <= orsf_pkg::FLAGS_RESET[orsf_pkg::BIT_A_GOOD];
    end else begin
      output_a_regained_flag_q <= output_a_regained_flag_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= orsf_pkg::RD_IDLE;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign flags = flag_word;
  assign rd_data = rd_data_q;
endmodule
`default_nettype wire

// ===== tb/orsf_checker.sv
// Flag checker
`timescale 1ns/1ps
`default_nettype none
module orsf_checker (
  input wire logic clk,
  input wire logic rst,
  input wire orsf_pkg::orsf_live_t live_good,
  input wire orsf_pkg::orsf_wr_t bus_wr,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire w = bus_wr.wr && bus_wr.addr == 8'h01;
  wire c = live_good.c;
  wire b = live_good.b;
  wire a = live_good.a;
  AST_CL: assert property ($fell(c) ##0 (!c && !w)[*6] |-> flags[5]) else $error("set");
  AST_B_LOW: assert property ($fell(b) ##0 (!b && !w)[*6] |-> flags[4])
    else $error("b low");
  AST_A_LOW: assert property ($fell(a) ##0 (!a && !w)[*6] |-> flags[3])
    else $error("a low");
  AST_C_GOOD: assert property ($rose(c) ##0 (c && !w)[*6] |-> flags[2])
    else $error("c good");
  AST_B_GOOD: assert property ($rose(b) ##0 (b && !w)[*6] |-> flags[1])
    else $error("b good");
  AST_A_GOOD: assert property ($rose(a) ##0 (a && !w)[*6] |-> flags[0])
    else $error("a good");
  AST_CLR: assert property ((~flags & $past(flags & ~(bus_wr.wdata & {8{w}}))) == 8'h00)
    else $error("clr");
  AST_RSVD: assert property (flags[7:6] == 2'h0)
    else $error("reserved");
  AST_RD: assert property (1'b1 |=> rd_data == (($past(rd_addr) == 8'h01) ? $past(flags) : 8'h00))
    else $error("read");
endmodule
bind orsf_flags orsf_checker chk_u (.clk, .rst, .live_good, .bus_wr, .rd_addr, .rd_data, .flags);
`default_nettype wire

// ===== tb/orsf_host.sv
// Host model
`timescale 1ns/1ps
`default_nettype none
module orsf_host (
  input wire logic clk,
  output var orsf_pkg::orsf_wr_t bus_wr
);
  initial bus_wr = '0;
  // One write: raised on a falling edge, dropped on the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) bus_wr = '{a, d & 8'h3F, 1'b1};
    @(negedge clk) bus_wr.wr = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Flag bench
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned ROUNDS = 40;
  // Eleven cycles a round, fourteen when late; the limit leaves ample margin
  localparam int unsigned LIMIT_NS = 20000;
  logic clk = 0;
  logic rst = 1;
  logic [31:0] s = 32'hA510F964;
  logic [7:0] e = 8'h00;
  logic [7:0] fl;
  logic [7:0] rd;
  logic [7:0] ra = 8'h00;
  orsf_pkg::orsf_live_t lg = '0;
  orsf_pkg::orsf_wr_t bw;
  int n_mismatch = 0;
  int n_tests = 0;
  orsf_flags dut_u (.clk, .rst, .live_good(lg), .bus_wr(bw), .rd_addr(ra), .rd_data(rd),
    .flags(fl));
  orsf_host host_u (.clk, .bus_wr(bw));
  initial forever #2.5 clk = ~clk;
  initial begin
    #(LIMIT_NS);
    n_mismatch++;
    conclude;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ x << 5;
  endfunction
  // Regulation state comes from the live levels, never from the sticky bits
  function automatic logic [7:0] exp_flags(input logic [7:0] old, input logic [7:0] wd,
    input logic [2:0] was, input logic [2:0] now);
    return ((old & ~wd) | {2'h0, was & ~now, now & ~was}) & orsf_pkg::FLAGS_IMPL_MASK;
  endfunction
  task conclude;
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Late puts the write on the very edge at which the new event sets its flag
  task automatic round(input logic [7:0] wa, input logic [7:0] wd, input logic [2:0] nl,
    input logic late, input logic [7:0] ra_next);
    logic [2:0] was;
    logic [7:0] rexp;
    was = lg;
    if (late) begin
      @(negedge clk);
      lg = nl;
      repeat (2) @(negedge clk);
      host_u.wr(wa, wd);
    end else begin
      host_u.wr(wa, wd);
      lg = nl;
    end
    e = exp_flags(e, (wa == orsf_pkg::FLAGS_ADDR) ? wd : 8'h00, was, nl);
    repeat (8) @(negedge clk);
    n_tests++;
    if (fl !== e) begin
      n_mismatch++;
      $display("ERROR flags exp %h got %h", e, fl);
    end
    ra = ra_next;
    rexp = (ra_next == orsf_pkg::FLAGS_ADDR) ? e : 8'h00;
    @(negedge clk);
    n_tests++;
    if (rd !== rexp) begin
      n_mismatch++;
      $display("ERROR rd_data exp %h got %h", rexp, rd);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    round(8'h01, 8'h00, 3'h7, 1'b0, 8'h01);
    round(8'h01, 8'hFF, 3'h0, 1'b1, 8'h01);
    round(8'h02, 8'hFF, 3'h7, 1'b0, 8'h02);
    round(8'h01, 8'hC0, 3'h7, 1'b0, 8'h01);
    repeat (ROUNDS) begin
      s = xs(s);
      round(s[8] ? orsf_pkg::FLAGS_ADDR : s[31:24], s[15:8], s[2:0], s[4],
        s[9] ? orsf_pkg::FLAGS_ADDR : s[23:16]);
    end
    conclude;
  end
endmodule
`default_nettype wire
